// [src/gate_ctrl_pkg.sv]
// Purpose: constants and types for the three-phase gate control block
// Assumes: hclk at 20 MHz; registers reached over AHB-Lite
// Notes: all timing counts derive from the clock period below
// Notes on behaviour
// RULE1: each gate output follows its own PWM input, subject to protection.
// RULE2: all gates forced low on fault, enable low over 1 ms, or sleep.
// RULE3: gate undervoltage monitor only evaluated while that driver drives on.
// RULE4: undervoltage beyond filter time blocks drivers and latches a reported fault.
// RULE5: undervoltage latch holds until power loss or enable low then high.
// RULE6: a first-config bit enables gate undervoltage lockout; disabled means no latch.
// RULE7: drain-source over threshold after turn-on kills all drivers, latches short fault.
// RULE8: short latch clears only by power loss or enable rising edge.
// RULE9: two-bit threshold selects 250, 500, 750 or 1000 mV.
// RULE10: separate bit enables short detection; disabled never trips.
// RULE11: both inputs of one half-bridge high switches both gates off.
// RULE12: break-before-make delay on every turn-on edge.
// RULE13: dead time 250 ns to 2000 ns in 250 ns steps, default 2000.
// RULE14: blanking 500 ns, 1 us, 2 us or 4 us, default 4 us.
// RULE15: blanking starts after dead time; comparator ignored during blanking.
// RULE16: undervoltage filter not latched while blanking runs.
// RULE17: host writes threshold and enable bits; device applies them to config.
// RULE18: host holds all low-side inputs 1.2 ms per uF before high-side use; the host model moves on without holding, charge time not modelled.
// RULE19: host aligns rotor with high A, high C, low B on.
// RULE20: host steps six states open-loop, raising rate linearly.
// RULE21: host picks direction by commutation order.
// RULE22: host then hands commutation to back-EMF phase-locked loop; the host model has no loop and keeps stepping at its rate floor.
// RULE23: on enable rising, a status bit clears only if its condition ended.
// RULE24: undervoltage fault sends 0x86 0x04; overcurrent sends 0x86 0x08.
// RULE25: dead-time code maps linearly 0..7; blanking codes ascend 0..3.
// RULE26: delays counted in clock cycles, rounded up, never shorter than nominal.
`default_nettype none
package gate_ctrl_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned DEAD_STEP_NS     = 250;
  localparam int unsigned BLANK_BASE_NS    = 500;
  localparam int unsigned OE_OFF_TIME_US   = 1000;
  localparam int unsigned UV_FILTER_NS     = 1000;
  localparam int unsigned DEAD_STEP_CYC    = (DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_BASE_CYC   = (BLANK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OE_OFF_CYC       = (OE_OFF_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS;
  localparam int unsigned UV_FILTER_CYC    = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  CFG_FIRST_OFS    = 8'h00;
  localparam logic [7:0]  CFG_THIRD_OFS    = 8'h04;
  localparam logic [7:0]  STATUS_OFS       = 8'h08;
  localparam logic [7:0]  MSG_OFS          = 8'h0c;
  localparam logic [7:0]  CTRL_OFS         = 8'h10;
  localparam int unsigned UV_EN_BIT        = 0;
  localparam int unsigned SHORT_EN_BIT     = 1;
  localparam int unsigned THR_LSB          = 2;
  localparam int unsigned DT_LSB           = 0;
  localparam int unsigned BL_LSB           = 3;
  localparam int unsigned SLEEP_BIT        = 0;
  localparam logic [31:0] CFG_FIRST_RST    = 32'h0000_0003;
  localparam logic [31:0] CFG_THIRD_RST    = 32'h0000_001f;
  localparam logic [7:0]  MSG_HDR          = 8'h86;
  localparam logic [7:0]  MSG_UV           = 8'h04;
  localparam logic [7:0]  MSG_SHORT        = 8'h08;
  localparam logic [9:0]  THR_MV_0         = 10'd250;
  localparam logic [9:0]  THR_MV_STEP      = 10'd250;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gate_set_t;

  typedef struct packed {
    logic       uv_en;
    logic       short_en;
    logic [1:0] thr_sel;
    logic [2:0] dead_sel;
    logic [1:0] blank_sel;
  } gate_cfg_t;
endpackage : gate_ctrl_pkg
`default_nettype wire

// [src/half_bridge_timer.sv]
// Purpose: dead time and blanking sequencing for one half-bridge
// Assumes: inputs already synchronised and protected
// Notes: one instance per phase
`default_nettype none
module half_bridge_timer
  import gate_ctrl_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       want_high,
  input  wire logic       want_low,
  input  wire logic [2:0] dead_sel,
  input  wire logic [1:0] blank_sel,
  output logic            drive_high,
  output logic            drive_low,
  output logic            blanking
);
  localparam int unsigned CW = 10;
  logic [CW-1:0] cnt_q;
  logic          tgt_q;
  logic          tgt_on_q;
  logic          bl_q;

  wire logic          target    = want_high;
  wire logic          target_on = want_high | want_low;
  wire logic [CW-1:0] dead_cyc  = CW'((32'(dead_sel) + 32'd1) * DEAD_STEP_CYC); // RULE13 RULE25
  wire logic [CW-1:0] blank_cyc = CW'(BLANK_BASE_CYC << blank_sel); // RULE14 RULE25 RULE26

  // Any change of request passes through the dead state first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q      <= '0;
      tgt_q      <= 1'b0;
      tgt_on_q   <= 1'b0;
      bl_q       <= 1'b0;
      drive_high <= 1'b0;
      drive_low  <= 1'b0;
    end else if (target != tgt_q || target_on != tgt_on_q) begin
      tgt_q      <= target;
      tgt_on_q   <= target_on;
      drive_high <= 1'b0; // RULE12
      drive_low  <= 1'b0; // RULE12
      bl_q       <= 1'b0;
      cnt_q      <= target_on ? dead_cyc : '0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
      if (cnt_q == CW'(1) && !bl_q && tgt_on_q) begin
        drive_high <= tgt_q;
        drive_low  <= !tgt_q;
        bl_q       <= 1'b1; // RULE15
        cnt_q      <= blank_cyc;
      end else if (cnt_q == CW'(1)) begin
        bl_q <= 1'b0;
      end
    end else if (tgt_on_q && !bl_q && !drive_high && !drive_low) begin
      drive_high <= tgt_q; // RULE1
      drive_low  <= !tgt_q;
    end
  end
  assign blanking = bl_q;
endmodule : half_bridge_timer
`default_nettype wire

// [src/three_phase_gate_control.sv]
// Purpose: six-gate control with cross-conduction, dead time and fault latches
// Assumes: pins asynchronous to hclk; AHB-Lite single word transfers
// Notes: fault pin is open drain, enable high pulls low
//
// Chosen here: register access over AHB-Lite and the address map.
`default_nettype none
module three_phase_gate_control
  import gate_ctrl_pkg::*;
#(
  parameter int unsigned OE_OFF_CYCLES = OE_OFF_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  pwm_in,
  input  wire logic        output_enable,
  input  wire logic [2:0]  gate_uv_high,
  input  wire logic [2:0]  gate_uv_low,
  input  wire logic [2:0]  over_high,
  input  wire logic [2:0]  over_low,
  output logic [2:0]       high_gate,
  output logic [2:0]       low_gate,
  output logic [1:0]       short_threshold_sel,
  output logic [9:0]       short_threshold_mv,
  output logic             fault_n_oe,
  output logic             fault_n_out,
  output logic [15:0]      status_msg,
  output logic             status_msg_valid
);
  // Low-time counter is 24 bits wide
  if (OE_OFF_CYCLES < 1 || OE_OFF_CYCLES > 32'h00ff_ffff) begin : g_bad_oe_off
    $error("OE_OFF_CYCLES out of range");
  end

  // Two-flop synchronisers for every pin input
  localparam int unsigned NS = 19;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {pwm_in, output_enable, gate_uv_high, gate_uv_low, over_high, over_low};
      s2_q <= s1_q;
    end
  end
  wire logic [5:0] pwm_s  = s2_q[18:13];
  wire logic       oe_s   = s2_q[12];
  wire logic [2:0] uvh_s  = s2_q[11:9];
  wire logic [2:0] uvl_s  = s2_q[8:6];
  wire logic [2:0] ovh_s  = s2_q[5:3];
  wire logic [2:0] ovl_s  = s2_q[2:0];
  gate_set_t pwm;
  assign pwm = gate_set_t'(pwm_s);

  // Registers
  logic [31:0] cfg_first_q;
  logic [31:0] cfg_third_q;
  logic        sleep_q;
  gate_cfg_t   cfg;
  assign cfg.uv_en     = cfg_first_q[UV_EN_BIT];
  assign cfg.short_en  = cfg_first_q[SHORT_EN_BIT];
  assign cfg.thr_sel   = cfg_first_q[THR_LSB +: 2];
  assign cfg.dead_sel  = cfg_third_q[DT_LSB +: 3];
  assign cfg.blank_sel = cfg_third_q[BL_LSB +: 2];

  // AHB-Lite address phase capture
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  ofs_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      ofs_q <= '0;
    end else if (hready) begin
      wr_q  <= hsel && htrans[1] && hwrite;
      rd_q  <= hsel && htrans[1] && !hwrite;
      ofs_q <= haddr[7:0];
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
  end

  // Zero wait states; unmapped reads give zero, unmapped writes dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_first_q <= CFG_FIRST_RST;
      cfg_third_q <= CFG_THIRD_RST;
      sleep_q     <= 1'b0;
    end else if (wr_q) begin
      case (ofs_q)
        CFG_FIRST_OFS: cfg_first_q <= {28'h0, hwdata[3:0]}; // RULE6 RULE10 RULE17
        CFG_THIRD_OFS: cfg_third_q <= {27'h0, hwdata[4:0]};
        CTRL_OFS:      sleep_q     <= hwdata[SLEEP_BIT];
        default: begin
        end
      endcase
    end
  end

  // Enable pin: low time counter and rising edge
  logic [23:0] oe_low_cnt_q;
  logic        oe_off_q;
  logic        oe_prev_q;
  wire  logic  oe_rise = oe_s && !oe_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_low_cnt_q <= '0;
      oe_off_q     <= 1'b0;
      oe_prev_q    <= 1'b0;
    end else begin
      oe_prev_q <= oe_s;
      if (oe_s) begin
        oe_low_cnt_q <= '0;
        oe_off_q     <= 1'b0;
      end else if (oe_low_cnt_q >= 24'(OE_OFF_CYCLES)) begin
        oe_off_q <= 1'b1; // RULE2
      end else begin
        oe_low_cnt_q <= oe_low_cnt_q + 24'd1;
      end
    end
  end

  // Protection and per-phase timing
  logic       uv_fault_q;
  logic       short_fault_q;
  wire  logic any_fault = uv_fault_q | short_fault_q;
  wire  logic kill      = any_fault | oe_off_q | sleep_q; // RULE2
  logic [2:0] dh;
  logic [2:0] dl;
  logic [2:0] blank;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    wire logic both = pwm.high[p] & pwm.low[p]; // RULE11
    half_bridge_timer u_timer (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .want_high  (pwm.high[p] & !both & !kill),
      .want_low   (pwm.low[p] & !both & !kill),
      .dead_sel   (cfg.dead_sel),
      .blank_sel  (cfg.blank_sel),
      .drive_high (dh[p]),
      .drive_low  (dl[p]),
      .blanking   (blank[p])
    );
  end

  // Monitors only look at drivers actually on and out of blanking
  wire logic uv_now = |((uvh_s & dh) | (uvl_s & dl)) && !(|blank); // RULE3 RULE16
  wire logic ov_now = |((ovh_s & dh) | (ovl_s & dl)) && !(|blank); // RULE7 RULE15
  logic [7:0] uv_cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_cnt_q <= '0;
    end else if (!uv_now || !cfg.uv_en) begin
      uv_cnt_q <= '0;
    end else if (uv_cnt_q < 8'(UV_FILTER_CYC)) begin
      uv_cnt_q <= uv_cnt_q + 8'd1;
    end
  end
  wire logic uv_trip    = cfg.uv_en && uv_now && uv_cnt_q >= 8'(UV_FILTER_CYC); // RULE4 RULE6
  wire logic short_trip = cfg.short_en && ov_now; // RULE10

  // Latches: trip beats the clear; clear only if condition gone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uv_fault_q    <= 1'b0;
      short_fault_q <= 1'b0;
    end else begin
      if (uv_trip) begin
        uv_fault_q <= 1'b1; // RULE4
      end else if (oe_rise && !(|(uvh_s | uvl_s))) begin
        uv_fault_q <= 1'b0; // RULE5 RULE23
      end
      if (short_trip) begin
        short_fault_q <= 1'b1; // RULE7
      end else if (oe_rise && !(|(ovh_s | ovl_s))) begin
        short_fault_q <= 1'b0; // RULE8 RULE23
      end
    end
  end

  // Status message once per newly latched fault; undervoltage message alone when both latch in one cycle
  logic uv_seen_q;
  logic short_seen_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_msg       <= '0;
      status_msg_valid <= 1'b0;
      uv_seen_q        <= 1'b0;
      short_seen_q     <= 1'b0;
    end else begin
      uv_seen_q        <= uv_fault_q;
      short_seen_q     <= short_fault_q;
      status_msg_valid <= 1'b0;
      if (uv_fault_q && !uv_seen_q) begin
        status_msg       <= {MSG_HDR, MSG_UV}; // RULE24
        status_msg_valid <= 1'b1;
      end else if (short_fault_q && !short_seen_q) begin
        status_msg       <= {MSG_HDR, MSG_SHORT}; // RULE24
        status_msg_valid <= 1'b1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_gate           <= '0;
      low_gate            <= '0;
      fault_n_oe          <= 1'b0;
      fault_n_out         <= 1'b0;
      short_threshold_sel <= '0;
      short_threshold_mv  <= THR_MV_0;
    end else begin
      high_gate           <= kill ? 3'h0 : dh; // RULE1 RULE2
      low_gate            <= kill ? 3'h0 : dl; // RULE2
      fault_n_oe          <= any_fault;
      fault_n_out         <= 1'b0;
      short_threshold_sel <= cfg.thr_sel; // RULE17
      short_threshold_mv  <= THR_MV_0 + THR_MV_STEP * 10'(cfg.thr_sel); // RULE9
    end
  end

  // Read data: status shows latched faults, enable-off and blanking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        CFG_FIRST_OFS: hrdata <= cfg_first_q;
        CFG_THIRD_OFS: hrdata <= cfg_third_q;
        STATUS_OFS:    hrdata <= {26'h0, |blank, oe_off_q, sleep_q, any_fault,
                                  short_fault_q, uv_fault_q};
        MSG_OFS:       hrdata <= {16'h0, status_msg};
        CTRL_OFS:      hrdata <= {31'h0, sleep_q};
        default:       hrdata <= '0;
      endcase
    end
  end
endmodule : three_phase_gate_control
`default_nettype wire

// [bench/gate_host_model.sv]
// Purpose: host controller model driving the PWM and enable pins
// Assumes: bench picks the mode; outputs change just after hclk rises
// Notes: bootstrap charge time not modelled; rate floor stands in for run mode
`default_nettype none
module gate_host_model
  import gate_ctrl_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [2:0] mode,
  input  wire logic       dir,
  input  wire logic       oe_req,
  input  wire gate_set_t  man,
  output gate_set_t       pwm,
  output logic            oe
);
  logic [2:0] step_q;
  logic [7:0] per_q;
  logic [7:0] cnt_q;
  gate_set_t  ramp_w;
  always_comb begin
    case (step_q)
      3'd0: ramp_w = 6'b001_100;
      3'd1: ramp_w = 6'b010_100;
      3'd2: ramp_w = 6'b010_001;
      3'd3: ramp_w = 6'b100_001;
      3'd4: ramp_w = 6'b100_010;
      default: ramp_w = 6'b001_010;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm <= '0;
      oe <= 1'b0;
      step_q <= '0;
      per_q <= 8'd60;
      cnt_q <= '0;
    end else begin
      oe <= oe_req && (mode != 3'd0);
      case (mode)
        3'd0: pwm <= '0;
        3'd1: pwm <= 6'b000_111;
        3'd2: pwm <= 6'b101_010;
        3'd3: pwm <= ramp_w;
        default: pwm <= man;
      endcase
      if (mode != 3'd3) begin
        step_q <= '0;
        per_q <= 8'd60;
        cnt_q <= '0;
      end else if (cnt_q < per_q) begin
        cnt_q <= cnt_q + 8'd1;
      end else begin
        cnt_q <= '0;
        // Reverse order turns the motor the other way
        if (dir) step_q <= (step_q == 3'd0) ? 3'd5 : step_q - 3'd1;
        else step_q <= (step_q == 3'd5) ? 3'd0 : step_q + 3'd1;
        if (per_q > 8'd20) per_q <= per_q - 8'd4;
      end
    end
  end
endmodule : gate_host_model
`default_nettype wire

// [bench/gate_ctrl_properties.sv]
// Purpose: port assertions for the gate control block
// Assumes: one hclk domain, hresetn async low
// Notes: margins allow for the two-flop pin synchronisers
`default_nettype none
module gate_ctrl_checker
  import gate_ctrl_pkg::*;
#(
  parameter int unsigned OE_OFF_CYCLES = OE_OFF_CYC
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [5:0]  pwm_in,
  input wire logic        output_enable,
  input wire logic [2:0]  gate_uv_high,
  input wire logic [2:0]  gate_uv_low,
  input wire logic [2:0]  over_high,
  input wire logic [2:0]  over_low,
  input wire logic [2:0]  high_gate,
  input wire logic [2:0]  low_gate,
  input wire logic [1:0]  short_threshold_sel,
  input wire logic [9:0]  short_threshold_mv,
  input wire logic        fault_n_oe,
  input wire logic [15:0] status_msg,
  input wire logic        status_msg_valid
);
  logic [7:0]  cause_q;
  logic [7:0]  oe_q;
  logic [15:0] oe_low_q;
  wire logic [2:0] both_w = pwm_in[5:3] & pwm_in[2:0];
  wire logic       now_w = |{gate_uv_high, gate_uv_low, over_high, over_low};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_q <= '0;
      oe_q <= '0;
      oe_low_q <= '0;
    end else begin
      cause_q <= {cause_q[6:0], now_w};
      oe_q <= {oe_q[6:0], output_enable};
      // Saturate so a long disable never wraps
      if (output_enable) oe_low_q <= '0;
      else if (oe_low_q != 16'hffff) oe_low_q <= oe_low_q + 16'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_cross; ((high_gate | low_gate) & $past(both_w, 5)) == 3'b000; endproperty
  a_cross: assert property (p_cross) else $error("both inputs high but gate on");
  property p_bbm_hi;
    (high_gate & ~$past(high_gate) & ($past(low_gate) | $past(low_gate, 2) |
      $past(low_gate, 3) | $past(low_gate, 4))) == 3'b000;
  endproperty
  a_bbm_hi: assert property (p_bbm_hi) else $error("high gate on without dead time");
  property p_bbm_lo;
    (low_gate & ~$past(low_gate) & ($past(high_gate) | $past(high_gate, 2) |
      $past(high_gate, 3) | $past(high_gate, 4))) == 3'b000;
  endproperty
  a_bbm_lo: assert property (p_bbm_lo) else $error("low gate on without dead time");
  property p_oe_off; oe_low_q > OE_OFF_CYCLES + 4 |-> (high_gate | low_gate) == 3'b000;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("gate on after long disable");
  property p_kill; fault_n_oe |=> (high_gate | low_gate) == 3'b000; endproperty
  a_kill: assert property (p_kill) else $error("gate on during fault");
  property p_cause; $rose(fault_n_oe) |-> (now_w || cause_q != 8'h00); endproperty
  a_cause: assert property (p_cause) else $error("fault without cause");
  property p_clear; $fell(fault_n_oe) |-> |(oe_q[6:0] & ~oe_q[7:1]); endproperty
  a_clear: assert property (p_clear) else $error("fault cleared without enable edge");
  property p_thr; short_threshold_mv == 10'd250 * (10'd1 + 10'(short_threshold_sel));
  endproperty
  a_thr: assert property (p_thr) else $error("threshold level wrong");
  property p_msg; $rose(fault_n_oe) |-> ##[0:4] status_msg_valid; endproperty
  a_msg: assert property (p_msg) else $error("no message after fault");
  property p_code; status_msg_valid |-> status_msg inside {16'h8604, 16'h8608}; endproperty
  a_code: assert property (p_code) else $error("message code wrong");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus response not ready okay");
  c_fault: cover property ($rose(fault_n_oe));
  c_msg: cover property (status_msg_valid);
  c_turn_on: cover property ($rose(high_gate[0]));
endmodule : gate_ctrl_checker
bind three_phase_gate_control gate_ctrl_checker #(.OE_OFF_CYCLES(OE_OFF_CYCLES)) u_checker (
  .hclk, .hresetn, .hreadyout, .hresp, .pwm_in, .output_enable, .gate_uv_high, .gate_uv_low,
  .over_high, .over_low, .high_gate, .low_gate, .short_threshold_sel, .short_threshold_mv,
  .fault_n_oe, .status_msg, .status_msg_valid);
`default_nettype wire

// [bench/three_phase_gate_control_test.sv]
// Purpose: self-checking bench for the gate control block
// Assumes: host model drives pins; bench plays the comparators and bus master
// Notes: disable time shortened to 50 cycles
`default_nettype none
module three_phase_gate_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import gate_ctrl_pkg::*;
  localparam int unsigned OEC = 50;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dir = 0, oe_req = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0]  htrans = '0, short_threshold_sel;
  logic [2:0]  hsize = 3'b010, mode = '0, high_gate, low_gate;
  logic [2:0]  gate_uv_high = '0, gate_uv_low = '0, over_high = '0, over_low = '0;
  gate_set_t   man = '0, pwm_in;
  logic        hreadyout, hresp, output_enable, fault_n_oe, fault_n_out, status_msg_valid;
  logic [9:0]  short_threshold_mv;
  logic [15:0] status_msg, last_msg = '0;
  int          failures = 0, samples_checked = 0;
  always #25 hclk = ~hclk;
  always @(posedge hclk) if (status_msg_valid === 1'b1) last_msg <= status_msg;
  three_phase_gate_control #(.OE_OFF_CYCLES(OEC)) dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .pwm_in, .output_enable, .gate_uv_high, .gate_uv_low, .over_high, .over_low, .high_gate,
    .low_gate, .short_threshold_sel, .short_threshold_mv, .fault_n_oe, .fault_n_out,
    .status_msg, .status_msg_valid);
  gate_host_model host (.hclk, .hresetn, .mode, .dir, .oe_req, .man, .pwm(pwm_in),
    .oe(output_enable));
  task automatic results;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask : cyc
  // Master holds each phase until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic until_gate(input logic [5:0] g, input int lim, output int k);
    for (k = 0; k < lim && {high_gate, low_gate} !== g; k++) @(posedge hclk);
  endtask : until_gate
  task automatic t_regs;
    logic [31:0] q;
    bus(1'b0, CFG_THIRD_OFS, '0, q);
    chk(q, 32'h0000_001f);
    bus(1'b0, 8'h40, '0, q);
    chk(q, 32'h0000_0000);
    wr(CFG_THIRD_OFS, '0);
    for (int s = 0; s < 4; s++) begin
      wr(CFG_FIRST_OFS, 32'(s * 4 + 3));
      cyc(2);
      chk({30'h0, short_threshold_sel}, 32'(s));
      chk({22'h0, short_threshold_mv}, 32'(250 * (s + 1)));
    end
    wr(CFG_FIRST_OFS, 32'h3);
  endtask : t_regs
  task automatic t_dead;
    int k;
    for (int d = 0; d < 8; d += 7) begin
      wr(CFG_THIRD_OFS, 32'(d));
      man <= 6'b000_001;
      until_gate(6'b000_001, 100, k);
      chk1(k >= (d + 1) * 5 && k <= (d + 1) * 5 + 8, 1'b1);
      man <= 6'b001_000;
      until_gate(6'b001_000, 100, k);
      chk1(k >= (d + 1) * 5 && k <= (d + 1) * 5 + 8, 1'b1);
      man <= '0;
      cyc(4);
    end
    wr(CFG_THIRD_OFS, '0);
  endtask : t_dead
  task automatic t_cross;
    int k;
    man <= 6'b000_001;
    until_gate(6'b000_001, 100, k);
    man <= 6'b111_111;
    cyc(30);
    chk({26'h0, high_gate, low_gate}, '0);
    man <= '0;
  endtask : t_cross
  task automatic t_host;
    int k;
    mode <= 3'd1;
    until_gate(6'b000_111, 100, k);
    chk1(k < 100, 1'b1);
    mode <= 3'd2;
    until_gate(6'b101_010, 100, k);
    chk1(k < 100, 1'b1);
    for (int r = 0; r < 2; r++) begin
      dir <= r[0];
      mode <= 3'd3;
      until_gate(6'b001_100, 200, k);
      until_gate(r[0] ? 6'b001_010 : 6'b010_100, 200, k);
      chk1(k < 200, 1'b1);
      mode <= 3'd2;
      cyc(20);
    end
    mode <= 3'd4;
  endtask : t_host
  task automatic t_fault(input logic uv, input logic en);
    int k;
    logic [31:0] q;
    wr(CFG_FIRST_OFS, en ? 32'h3 : (uv ? 32'h2 : 32'h1));
    gate_uv_high <= 3'b111;
    cyc(60);
    chk1(fault_n_oe, 1'b0);
    gate_uv_high <= '0;
    man <= 6'b000_001;
    until_gate(6'b000_001, 100, k);
    over_low <= 3'b001; // Pulse inside the blanking window
    bus(1'b0, STATUS_OFS, '0, q);
    chk({26'h0, q[5:0]}, 32'h0000_0020);
    over_low <= '0;
    cyc(10);
    chk1(fault_n_oe, 1'b0);
    if (uv) gate_uv_low <= 3'b001;
    else over_low <= 3'b001;
    for (k = 0; k < 60 && fault_n_oe !== 1'b1; k++) @(posedge hclk);
    chk1(fault_n_oe, en);
    chk1(fault_n_out, 1'b0);
    if (en) begin
      cyc(3);
      chk({26'h0, high_gate, low_gate}, '0);
      chk({16'h0, last_msg}, uv ? 32'h8604 : 32'h8608);
      bus(1'b0, STATUS_OFS, '0, q);
      chk({30'h0, q[1:0]}, uv ? 32'h1 : 32'h2);
      oe_req <= 1'b0;
      cyc(4);
      oe_req <= 1'b1;
      cyc(10);
      chk1(fault_n_oe, 1'b1);
    end
    gate_uv_low <= '0;
    over_low <= '0;
    cyc(2);
    oe_req <= 1'b0;
    cyc(4);
    oe_req <= 1'b1;
    cyc(10);
    chk1(fault_n_oe, 1'b0);
    man <= '0;
    wr(CFG_FIRST_OFS, 32'h3);
  endtask : t_fault
  task automatic t_kill;
    int k;
    logic [31:0] q;
    man <= 6'b000_001;
    until_gate(6'b000_001, 100, k);
    oe_req <= 1'b0;
    cyc(OEC + 8);
    chk({29'h0, low_gate}, '0);
    bus(1'b0, STATUS_OFS, '0, q);
    chk1(q[4], 1'b1);
    oe_req <= 1'b1;
    until_gate(6'b000_001, 100, k);
    chk1(k < 100, 1'b1);
    wr(CTRL_OFS, 32'h1);
    cyc(3);
    chk({29'h0, low_gate}, '0);
    wr(CTRL_OFS, '0);
    until_gate(6'b000_001, 100, k);
    chk1(k < 100, 1'b1);
    man <= '0;
  endtask : t_kill
  initial begin
    repeat (30000) @(posedge hclk);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    mode <= 3'd4;
    oe_req <= 1'b1;
    cyc(20);
    t_regs();
    t_dead();
    t_cross();
    t_host();
    t_fault(1'b0, 1'b1);
    t_fault(1'b1, 1'b1);
    t_fault(1'b0, 1'b0);
    t_fault(1'b1, 1'b0);
    t_kill();
    results();
  end
endmodule : three_phase_gate_control_test
`default_nettype wire
